// ### pkg/rstc_defs.vh
// constants for the read session and trigger control block
`ifndef RSTC_DEFS_VH
`define RSTC_DEFS_VH

// timing
`define RSTC_CLK_KHZ 25000
`define RSTC_TICK_MS 10
// 10 ms of the 25 MHz clock, sized to the tick counter
`define RSTC_TICK_CYCLES 18'h3D090
`define RSTC_TICKS_PER_SEC 14'h0064
`define RSTC_TENFOLD_MULT 14'h000A
`define RSTC_TICK_W 18
`define RSTC_LIMIT_W 14

// read time codes on READ_TIME_CODE
`define RSTC_RT_SYNC 4'h0
`define RSTC_RT_SEC_MAX 4'h9
`define RSTC_RT_UNLIMITED 4'hA
`define RSTC_RT_TENFOLD 4'hB

// read time modes
`define RSTC_MODE_SYNC 2'h0
`define RSTC_MODE_TIMED 2'h1
`define RSTC_MODE_UNLIM 2'h2

// session states, one-hot
`define RSTC_ST_IDLE 3'h1
`define RSTC_ST_READ 3'h2
`define RSTC_ST_SUSP 3'h4

// configuration reset values
`define RSTC_RST_POL_HIGH 1'h0
`define RSTC_RST_ACCEPT 1'h1
`define RSTC_RST_BUF_EN 1'h1
`define RSTC_RST_FROM_START 1'h0
`define RSTC_RST_MODE `RSTC_MODE_SYNC

`endif

// ### core/rstc_tick.v
// 10 ms tick generator for read time measurement
`include "rstc_defs.vh"

module rstc_tick #(
	parameter [`RSTC_TICK_W-1:0] TICK_CYCLES = `RSTC_TICK_CYCLES
) (
	input wire clk,
	input wire rst_n,
	input wire clear,
	output reg tick
);
	reg [`RSTC_TICK_W-1:0] cnt_reg;

	// restart the phase at each session start so the first tick is a full 10 ms
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= {`RSTC_TICK_W{1'b0}};
			tick <= 1'b0;
		end else if (clear) begin
			cnt_reg <= {`RSTC_TICK_W{1'b0}};
			tick <= 1'b0;
		end else if (cnt_reg == TICK_CYCLES - 1'b1) begin
			cnt_reg <= {`RSTC_TICK_W{1'b0}};
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // rstc_tick

// ### core/rstc_ctrl.v
// read session and trigger control: session state, read time limit, result strobes
`include "rstc_defs.vh"

module rstc_ctrl #(
	parameter [`RSTC_TICK_W-1:0] TICK_CYCLES = `RSTC_TICK_CYCLES
) (
	input wire CLK,
	input wire RST_N,
	input wire TRIGGER_IN_N,
	input wire TRIG_POLARITY_HIGH_CMD,
	input wire TRIG_POLARITY_LOW_CMD,
	input wire TRIG_ACCEPTANCE_CMD,
	input wire TRIG_ACCEPT_VAL,
	input wire START_FROM_END_CMD,
	input wire START_FROM_START_CMD,
	input wire OUT_BUFFER_OFF_CMD,
	input wire OUT_BUFFER_ON_CMD,
	input wire HANDSHAKE_EN,
	input wire READ_TIME_CMD,
	input wire [3:0] READ_TIME_CODE,
	input wire EXTENDED_READ_TIME_CMD,
	input wire [3:0] EXT_DIGIT_A,
	input wire [3:0] EXT_DIGIT_B,
	input wire [3:0] EXT_DIGIT_C,
	input wire [3:0] EXT_DIGIT_D,
	input wire START_READ_CMD,
	input wire STOP_READ_CMD,
	input wire AUTO_TRIGGER_EN,
	input wire AUTO_READ_DONE,
	input wire CODE_IN_IMAGE,
	input wire DECODE_OK,
	input wire TX_BUSY,
	input wire GOOD_READ_AIM_EN,
	output reg SESSION_ACTIVE,
	output reg ACQUIRE_EN,
	output reg DECODE_REQ,
	output reg TX_START,
	output reg GOOD_READ_OUT,
	output reg FAILED_READ_OUT,
	output reg GREEN_LED_PULSE,
	output reg BUZZER_PULSE,
	output reg AIMING_PULSE,
	output reg BUFFER_ACTIVE
);
	localparam [2:0] ST_IDLE = `RSTC_ST_IDLE;
	localparam [2:0] ST_READ = `RSTC_ST_READ;
	localparam [2:0] ST_SUSP = `RSTC_ST_SUSP;

	// configuration
	reg pol_high_reg;
	reg accept_reg;
	reg buf_en_reg;
	reg from_start_reg;
	reg [1:0] mode_reg;
	reg [3:0] sec_reg;
	reg tenfold_reg;
	reg ext_used_reg;
	reg [`RSTC_LIMIT_W-1:0] ext_reg;
	reg [`RSTC_LIMIT_W-1:0] limit_reg;
	reg [`RSTC_LIMIT_W-1:0] limit_next;

	// session
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg trig_act_reg;
	reg trig_prev_reg;
	reg by_cmd_reg;
	reg timer_run_reg;
	reg [`RSTC_LIMIT_W-1:0] elapsed_reg;
	wire tick;
	wire buffered;
	wire trig_rise;
	wire trig_fall;
	wire start_req;
	wire expired;
	wire sync_mode;
	wire fail_end;
	wire success;
	wire stop_now;
	wire session_start;

	// decimal digits to a count of 10 ms ticks
	function [`RSTC_LIMIT_W-1:0] dec4;
		input [3:0] a;
		input [3:0] b;
		input [3:0] c;
		input [3:0] d;
		begin
			dec4 = a * 14'h03E8 + b * 14'h0064 + c * 14'h000A + {10'h000, d};
		end
	endfunction

	rstc_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(CLK),
		.rst_n(RST_N),
		.clear(session_start),
		.tick(tick)
	);

	// handshaking overrides the buffer setting
	assign buffered = buf_en_reg & ~HANDSHAKE_EN;

	// trigger edges after polarity and acceptance
	assign trig_rise = trig_act_reg & ~trig_prev_reg;
	assign trig_fall = ~trig_act_reg & trig_prev_reg;
	assign sync_mode = (mode_reg == `RSTC_MODE_SYNC);
	assign start_req = START_READ_CMD | trig_rise;
	assign session_start = (state_reg == ST_IDLE) & start_req;

	// timed limit reached; a zero limit means nothing to wait for
	assign expired = (mode_reg == `RSTC_MODE_TIMED) & timer_run_reg & (elapsed_reg >= limit_reg);

	// session end conditions while reading
	assign stop_now = STOP_READ_CMD;
	assign success = DECODE_OK;
	assign fail_end = expired
		| (sync_mode & ~by_cmd_reg & ~AUTO_TRIGGER_EN & trig_fall)
		| (sync_mode & AUTO_TRIGGER_EN & AUTO_READ_DONE);

	// trigger level: polarity select, acceptance gate
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			trig_act_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
		end else begin
			trig_act_reg <= accept_reg & (pol_high_reg ? TRIGGER_IN_N : ~TRIGGER_IN_N);
			trig_prev_reg <= trig_act_reg;
		end
	end

	// configuration commands
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pol_high_reg <= `RSTC_RST_POL_HIGH;
			accept_reg <= `RSTC_RST_ACCEPT;
			buf_en_reg <= `RSTC_RST_BUF_EN;
			from_start_reg <= `RSTC_RST_FROM_START;
		end else begin
			if (TRIG_POLARITY_HIGH_CMD) begin
				pol_high_reg <= 1'b1;
			end else if (TRIG_POLARITY_LOW_CMD) begin
				pol_high_reg <= 1'b0;
			end
			if (TRIG_ACCEPTANCE_CMD) begin
				accept_reg <= TRIG_ACCEPT_VAL;
			end
			if (OUT_BUFFER_OFF_CMD) begin
				buf_en_reg <= 1'b0;
			end else if (OUT_BUFFER_ON_CMD) begin
				buf_en_reg <= 1'b1;
			end
			if (START_FROM_START_CMD) begin
				from_start_reg <= 1'b1;
			end else if (START_FROM_END_CMD) begin
				from_start_reg <= 1'b0;
			end
		end
	end

	// read time codes; the later command wins, extended in the same cycle; a tenfold code leaves an extended time in force
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_reg <= `RSTC_RST_MODE;
			sec_reg <= 4'h0;
			tenfold_reg <= 1'b0;
			ext_used_reg <= 1'b0;
			ext_reg <= {`RSTC_LIMIT_W{1'b0}};
		end else if (EXTENDED_READ_TIME_CMD) begin
			ext_reg <= dec4(EXT_DIGIT_A, EXT_DIGIT_B, EXT_DIGIT_C, EXT_DIGIT_D);
			ext_used_reg <= 1'b1;
			// zero extended time falls back to trigger synchronisation
			if (dec4(EXT_DIGIT_A, EXT_DIGIT_B, EXT_DIGIT_C, EXT_DIGIT_D) == {`RSTC_LIMIT_W{1'b0}}) begin
				mode_reg <= `RSTC_MODE_SYNC;
			end else begin
				mode_reg <= `RSTC_MODE_TIMED;
			end
		end else if (READ_TIME_CMD) begin
			if (READ_TIME_CODE == `RSTC_RT_SYNC) begin
				mode_reg <= `RSTC_MODE_SYNC;
				ext_used_reg <= 1'b0;
				tenfold_reg <= 1'b0;
			end else if (READ_TIME_CODE <= `RSTC_RT_SEC_MAX) begin
				mode_reg <= `RSTC_MODE_TIMED;
				sec_reg <= READ_TIME_CODE;
				ext_used_reg <= 1'b0;
				tenfold_reg <= 1'b0;
			end else if (READ_TIME_CODE == `RSTC_RT_UNLIMITED) begin
				mode_reg <= `RSTC_MODE_UNLIM;
				ext_used_reg <= 1'b0;
			end else if (READ_TIME_CODE == `RSTC_RT_TENFOLD) begin
				tenfold_reg <= 1'b1;
			end
		end
	end

	// limit in ticks; tenfold scales the coded seconds only
	always @* begin
		limit_next = {10'h000, sec_reg} * `RSTC_TICKS_PER_SEC;
		if (tenfold_reg) begin
			limit_next = limit_next * `RSTC_TENFOLD_MULT;
		end
		if (ext_used_reg) begin
			limit_next = ext_reg;
		end
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			limit_reg <= {`RSTC_LIMIT_W{1'b0}};
		end else begin
			limit_reg <= limit_next;
		end
	end

	// session state: suspend while unbuffered output runs
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start_req) begin
					if (!buffered && TX_BUSY) begin
						state_next = ST_SUSP;
					end else begin
						state_next = ST_READ;
					end
				end
			end
			ST_READ: begin
				if (stop_now || success || fail_end) begin
					state_next = ST_IDLE;
				end else if (!buffered && TX_BUSY) begin
					state_next = ST_SUSP;
				end
			end
			ST_SUSP: begin
				if (stop_now) begin
					state_next = ST_IDLE;
				end else if (fail_end && !expired) begin
					state_next = ST_IDLE;
				end else if (buffered || !TX_BUSY) begin
					state_next = ST_READ;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// session source and read time timer
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			by_cmd_reg <= 1'b0;
			timer_run_reg <= 1'b0;
			elapsed_reg <= {`RSTC_LIMIT_W{1'b0}};
		end else if (session_start) begin
			by_cmd_reg <= START_READ_CMD;
			// command start counts at once; trigger start per start-timing choice
			timer_run_reg <= START_READ_CMD | from_start_reg;
			elapsed_reg <= {`RSTC_LIMIT_W{1'b0}};
		end else if (state_reg == ST_IDLE) begin
			timer_run_reg <= 1'b0;
		end else begin
			if (trig_fall && !by_cmd_reg) begin
				timer_run_reg <= 1'b1;
			end
			// the timer stands still while operations are suspended
			if (timer_run_reg && tick && state_reg == ST_READ && !expired) begin
				elapsed_reg <= elapsed_reg + 1'b1;
			end
		end
	end

	// outputs; result levels hold until the next session begins
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SESSION_ACTIVE <= 1'b0;
			ACQUIRE_EN <= 1'b0;
			DECODE_REQ <= 1'b0;
			TX_START <= 1'b0;
			GOOD_READ_OUT <= 1'b0;
			FAILED_READ_OUT <= 1'b0;
			GREEN_LED_PULSE <= 1'b0;
			BUZZER_PULSE <= 1'b0;
			AIMING_PULSE <= 1'b0;
			BUFFER_ACTIVE <= `RSTC_RST_BUF_EN;
		end else begin
			SESSION_ACTIVE <= (state_next != ST_IDLE);
			ACQUIRE_EN <= (state_next == ST_READ);
			DECODE_REQ <= (state_reg == ST_READ) & CODE_IN_IMAGE & ~stop_now;
			BUFFER_ACTIVE <= buffered;
			TX_START <= 1'b0;
			GREEN_LED_PULSE <= 1'b0;
			BUZZER_PULSE <= 1'b0;
			AIMING_PULSE <= 1'b0;
			if (session_start) begin
				GOOD_READ_OUT <= 1'b0;
				FAILED_READ_OUT <= 1'b0;
			end else if (state_reg == ST_READ && !stop_now) begin
				if (success) begin
					TX_START <= 1'b1;
					GOOD_READ_OUT <= 1'b1;
					GREEN_LED_PULSE <= 1'b1;
					BUZZER_PULSE <= 1'b1;
					AIMING_PULSE <= GOOD_READ_AIM_EN;
				end else if (fail_end) begin
					FAILED_READ_OUT <= 1'b1;
				end
			end else if (state_reg == ST_SUSP && !stop_now && fail_end && !expired) begin
				FAILED_READ_OUT <= 1'b1;
			end
		end
	end
endmodule // rstc_ctrl

// ### sim/rstc_host_sink.sv
// far-side model that drains decoded data after each transmit start
module rstc_host_sink #(
	parameter int BUSY_CYCLES = 60
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tx_start,
	output logic tx_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt_reg;
	// output stays busy long enough to overlap a following session
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_reg <= 0;
		else if (tx_start)
			cnt_reg <= BUSY_CYCLES;
		else if (cnt_reg > 0)
			cnt_reg <= cnt_reg - 1;
	end
	assign tx_busy = cnt_reg > 0;
endmodule // rstc_host_sink

// ### sim/rstc_ctrl_properties.sv
// assertions on the ports of the read session control
module rstc_ctrl_checker (
	input wire CLK,
	input wire RST_N,
	input wire START_READ_CMD,
	input wire STOP_READ_CMD,
	input wire CODE_IN_IMAGE,
	input wire DECODE_OK,
	input wire TX_BUSY,
	input wire GOOD_READ_AIM_EN,
	input wire HANDSHAKE_EN,
	input wire SESSION_ACTIVE,
	input wire ACQUIRE_EN,
	input wire DECODE_REQ,
	input wire TX_START,
	input wire GOOD_READ_OUT,
	input wire FAILED_READ_OUT,
	input wire GREEN_LED_PULSE,
	input wire BUZZER_PULSE,
	input wire AIMING_PULSE,
	input wire BUFFER_ACTIVE
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// success in a plain read; busy excluded, though success wins over a suspend
	sequence s_hit;
		DECODE_OK && ACQUIRE_EN && !STOP_READ_CMD && !TX_BUSY;
	endsequence
	// handshake held, output busy, session open
	sequence s_busy_held;
		HANDSHAKE_EN [*2] ##0 (TX_BUSY && SESSION_ACTIVE);
	endsequence
	a_success_strobes: assert property (s_hit |=> TX_START && GREEN_LED_PULSE && BUZZER_PULSE)
		else $error("success strobes missing");
	a_good_result: assert property (s_hit |=> GOOD_READ_OUT && !FAILED_READ_OUT && !SESSION_ACTIVE)
		else $error("good result wrong");
	a_aim_gated: assert property (s_hit |=> AIMING_PULSE == $past(GOOD_READ_AIM_EN))
		else $error("aiming pulse wrong");
	a_code_decode: assert property (CODE_IN_IMAGE && ACQUIRE_EN && !STOP_READ_CMD |=> DECODE_REQ)
		else $error("decode request missing");
	a_idle_quiet: assert property (!ACQUIRE_EN |=> !DECODE_REQ && !TX_START)
		else $error("activity outside read");
	a_start_opens: assert property (!SESSION_ACTIVE && START_READ_CMD |=> SESSION_ACTIVE)
		else $error("start not taken");
	a_stop_closes: assert property (SESSION_ACTIVE && STOP_READ_CMD |=> !SESSION_ACTIVE)
		else $error("stop not taken");
	a_handshake_unbuffered: assert property (HANDSHAKE_EN |=> !BUFFER_ACTIVE)
		else $error("buffering kept");
	a_suspend_busy: assert property (s_busy_held |=> !ACQUIRE_EN)
		else $error("read during output");
endmodule // rstc_ctrl_checker
bind rstc_ctrl rstc_ctrl_checker u_chk (
	.CLK(CLK),
	.RST_N(RST_N),
	.START_READ_CMD(START_READ_CMD),
	.STOP_READ_CMD(STOP_READ_CMD),
	.CODE_IN_IMAGE(CODE_IN_IMAGE),
	.DECODE_OK(DECODE_OK),
	.TX_BUSY(TX_BUSY),
	.GOOD_READ_AIM_EN(GOOD_READ_AIM_EN),
	.HANDSHAKE_EN(HANDSHAKE_EN),
	.SESSION_ACTIVE(SESSION_ACTIVE),
	.ACQUIRE_EN(ACQUIRE_EN),
	.DECODE_REQ(DECODE_REQ),
	.TX_START(TX_START),
	.GOOD_READ_OUT(GOOD_READ_OUT),
	.FAILED_READ_OUT(FAILED_READ_OUT),
	.GREEN_LED_PULSE(GREEN_LED_PULSE),
	.BUZZER_PULSE(BUZZER_PULSE),
	.AIMING_PULSE(AIMING_PULSE),
	.BUFFER_ACTIVE(BUFFER_ACTIVE)
);

// ### sim/test_rstc_ctrl.sv
// self-checking bench for the read session control
module test_rstc_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK = 1'h0, RST_N = 1'h0, TRIGGER_IN_N = 1'h1, TRIG_ACCEPT_VAL = 1'h1, HANDSHAKE_EN = 1'h0;
	logic TRIG_POLARITY_HIGH_CMD = 1'h0, TRIG_POLARITY_LOW_CMD = 1'h0, TRIG_ACCEPTANCE_CMD = 1'h0;
	logic START_FROM_END_CMD = 1'h0, START_FROM_START_CMD = 1'h0, OUT_BUFFER_OFF_CMD = 1'h0;
	logic OUT_BUFFER_ON_CMD = 1'h0, READ_TIME_CMD = 1'h0, EXTENDED_READ_TIME_CMD = 1'h0;
	logic [3:0] READ_TIME_CODE = 4'h0, EXT_DIGIT_A = 4'h0, EXT_DIGIT_B = 4'h0;
	logic [3:0] EXT_DIGIT_C = 4'h2, EXT_DIGIT_D = 4'h5;
	logic START_READ_CMD = 1'h0, STOP_READ_CMD = 1'h0, AUTO_TRIGGER_EN = 1'h0, AUTO_READ_DONE = 1'h0;
	logic CODE_IN_IMAGE = 1'h0, DECODE_OK = 1'h0, GOOD_READ_AIM_EN = 1'h1, TX_BUSY;
	logic SESSION_ACTIVE, ACQUIRE_EN, DECODE_REQ, TX_START, GOOD_READ_OUT, FAILED_READ_OUT;
	logic GREEN_LED_PULSE, BUZZER_PULSE, AIMING_PULSE, BUFFER_ACTIVE;
	int num_errors = 0, tests_run = 0, waited = 0, cycles = 0;
	// short tick keeps second-long limits within the run
	rstc_ctrl #(.TICK_CYCLES(18'h0000A)) dut (
		.CLK(CLK),
		.RST_N(RST_N),
		.TRIGGER_IN_N(TRIGGER_IN_N),
		.TRIG_POLARITY_HIGH_CMD(TRIG_POLARITY_HIGH_CMD),
		.TRIG_POLARITY_LOW_CMD(TRIG_POLARITY_LOW_CMD),
		.TRIG_ACCEPTANCE_CMD(TRIG_ACCEPTANCE_CMD),
		.TRIG_ACCEPT_VAL(TRIG_ACCEPT_VAL),
		.START_FROM_END_CMD(START_FROM_END_CMD),
		.START_FROM_START_CMD(START_FROM_START_CMD),
		.OUT_BUFFER_OFF_CMD(OUT_BUFFER_OFF_CMD),
		.OUT_BUFFER_ON_CMD(OUT_BUFFER_ON_CMD),
		.HANDSHAKE_EN(HANDSHAKE_EN),
		.READ_TIME_CMD(READ_TIME_CMD),
		.READ_TIME_CODE(READ_TIME_CODE),
		.EXTENDED_READ_TIME_CMD(EXTENDED_READ_TIME_CMD),
		.EXT_DIGIT_A(EXT_DIGIT_A),
		.EXT_DIGIT_B(EXT_DIGIT_B),
		.EXT_DIGIT_C(EXT_DIGIT_C),
		.EXT_DIGIT_D(EXT_DIGIT_D),
		.START_READ_CMD(START_READ_CMD),
		.STOP_READ_CMD(STOP_READ_CMD),
		.AUTO_TRIGGER_EN(AUTO_TRIGGER_EN),
		.AUTO_READ_DONE(AUTO_READ_DONE),
		.CODE_IN_IMAGE(CODE_IN_IMAGE),
		.DECODE_OK(DECODE_OK),
		.TX_BUSY(TX_BUSY),
		.GOOD_READ_AIM_EN(GOOD_READ_AIM_EN),
		.SESSION_ACTIVE(SESSION_ACTIVE),
		.ACQUIRE_EN(ACQUIRE_EN),
		.DECODE_REQ(DECODE_REQ),
		.TX_START(TX_START),
		.GOOD_READ_OUT(GOOD_READ_OUT),
		.FAILED_READ_OUT(FAILED_READ_OUT),
		.GREEN_LED_PULSE(GREEN_LED_PULSE),
		.BUZZER_PULSE(BUZZER_PULSE),
		.AIMING_PULSE(AIMING_PULSE),
		.BUFFER_ACTIVE(BUFFER_ACTIVE)
	);
	rstc_host_sink u_sink (.clk(CLK), .rst_n(RST_N), .tx_start(TX_START), .tx_busy(TX_BUSY));
	always #20 CLK = ~CLK;
	task cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'h1) begin
			num_errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task wait_sa(input logic v);
		waited = 0;
		while (SESSION_ACTIVE !== v && waited < 3000) begin
			cyc(1);
			waited++;
		end
		// a wait that runs out is a failure, not a silent pass
		if (waited >= 3000) begin
			num_errors++;
			$display("BAD %0t wait limit", $time);
		end
	endtask
	task start_cmd;
		START_READ_CMD = 1'h1;
		cyc(1);
		START_READ_CMD = 1'h0;
		wait_sa(1'h1);
	endtask
	task stop_cmd;
		STOP_READ_CMD = 1'h1;
		cyc(1);
		STOP_READ_CMD = 1'h0;
		wait_sa(1'h0);
	endtask
	task decode_ok;
		DECODE_OK = 1'h1;
		cyc(1);
		DECODE_OK = 1'h0;
	endtask
	task set_code(input logic [3:0] c);
		READ_TIME_CMD = 1'h1;
		READ_TIME_CODE = c;
		cyc(1);
		READ_TIME_CMD = 1'h0;
	endtask
	// ticks are ten cycles here, so the end lands near the cycle figure
	task timed_run(input int exp_cyc);
		start_cmd();
		wait_sa(1'h0);
		chk(FAILED_READ_OUT === 1'h1 && waited > exp_cyc - 12 && waited < exp_cyc + 12, "timed end");
	endtask
	// high-active trigger held 100 cycles; end measured from release
	task trig_timed(input int lo, input int hi);
		TRIGGER_IN_N = 1'h1;
		wait_sa(1'h1);
		cyc(100);
		TRIGGER_IN_N = 1'h0;
		wait_sa(1'h0);
		chk(FAILED_READ_OUT === 1'h1 && waited > lo && waited < hi, "trig timed");
	endtask
	task close_out;
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	// main sequence
	initial begin
		cyc(2);
		RST_N = 1'h1;
		cyc(2);
		chk(BUFFER_ACTIVE === 1'h1, "buffer reset");
		TRIGGER_IN_N = 1'h0;
		wait_sa(1'h1);
		cyc(20);
		chk(ACQUIRE_EN === 1'h1 && waited < 6, "trig hold");
		TRIGGER_IN_N = 1'h1;
		wait_sa(1'h0);
		chk(FAILED_READ_OUT === 1'h1 && waited < 5, "trig end");
		start_cmd();
		CODE_IN_IMAGE = 1'h1;
		cyc(1);
		CODE_IN_IMAGE = 1'h0;
		chk(DECODE_REQ === 1'h1 && FAILED_READ_OUT === 1'h0, "decode req");
		decode_ok();
		chk(TX_START === 1'h1 && BUZZER_PULSE === 1'h1 && AIMING_PULSE === 1'h1, "strobes");
		chk(GOOD_READ_OUT === 1'h1 && SESSION_ACTIVE === 1'h0, "good");
		start_cmd();
		cyc(3);
		chk(ACQUIRE_EN === 1'h1 && TX_BUSY === 1'h1, "buffered");
		stop_cmd();
		chk(GOOD_READ_OUT === 1'h0 && FAILED_READ_OUT === 1'h0 && waited < 3, "stop");
		// let the earlier output drain so the first pass starts in read
		while (TX_BUSY !== 1'h0) cyc(1);
		for (int i = 0; i < 2; i++) begin
			OUT_BUFFER_OFF_CMD = (i == 0);
			OUT_BUFFER_ON_CMD = (i == 1);
			HANDSHAKE_EN = (i == 1);
			cyc(1);
			OUT_BUFFER_OFF_CMD = 1'h0;
			OUT_BUFFER_ON_CMD = 1'h0;
			start_cmd();
			decode_ok();
			start_cmd();
			cyc(3);
			chk(ACQUIRE_EN === 1'h0 && BUFFER_ACTIVE === 1'h0, "suspend");
			cyc(70);
			chk(ACQUIRE_EN === 1'h1, "resume");
			stop_cmd();
		end
		HANDSHAKE_EN = 1'h0;
		EXTENDED_READ_TIME_CMD = 1'h1;
		cyc(1);
		EXTENDED_READ_TIME_CMD = 1'h0;
		timed_run(250);
		set_code(4'h1);
		timed_run(1000);
		start_cmd();
		cyc(50);
		stop_cmd();
		chk(FAILED_READ_OUT === 1'h0, "early stop");
		for (int i = 0; i < 3; i++) begin
			// second pass: one second scaled tenfold outlasts the wait
			if (i == 1) set_code(4'h1);
			set_code(i == 0 ? 4'hA : (i == 1 ? 4'hB : 4'h0));
			start_cmd();
			cyc(1200);
			chk(SESSION_ACTIVE === 1'h1, "no limit");
			stop_cmd();
		end
		TRIG_ACCEPTANCE_CMD = 1'h1;
		TRIG_ACCEPT_VAL = 1'h0;
		cyc(1);
		TRIG_ACCEPTANCE_CMD = 1'h0;
		TRIGGER_IN_N = 1'h0;
		cyc(10);
		chk(SESSION_ACTIVE === 1'h0, "ignored");
		TRIG_POLARITY_HIGH_CMD = 1'h1;
		cyc(1);
		TRIG_POLARITY_HIGH_CMD = 1'h0;
		TRIG_ACCEPTANCE_CMD = 1'h1;
		TRIG_ACCEPT_VAL = 1'h1;
		cyc(1);
		TRIG_ACCEPTANCE_CMD = 1'h0;
		cyc(5);
		chk(SESSION_ACTIVE === 1'h0, "high idle");
		TRIGGER_IN_N = 1'h1;
		wait_sa(1'h1);
		chk(waited < 5, "high start");
		TRIGGER_IN_N = 1'h0;
		wait_sa(1'h0);
		chk(FAILED_READ_OUT === 1'h1 && waited < 5, "high end");
		// 25 ticks counted from trigger end, then from trigger start
		EXTENDED_READ_TIME_CMD = 1'h1;
		cyc(1);
		EXTENDED_READ_TIME_CMD = 1'h0;
		trig_timed(238, 262);
		START_FROM_START_CMD = 1'h1;
		cyc(1);
		START_FROM_START_CMD = 1'h0;
		trig_timed(140, 165);
		// auto trigger in synchronised mode: image processing ends it
		set_code(4'h0);
		AUTO_TRIGGER_EN = 1'h1;
		start_cmd();
		cyc(5);
		AUTO_READ_DONE = 1'h1;
		cyc(1);
		AUTO_READ_DONE = 1'h0;
		chk(SESSION_ACTIVE === 1'h0 && FAILED_READ_OUT === 1'h1, "auto end");
		AUTO_TRIGGER_EN = 1'h0;
		close_out();
	end
endmodule // test_rstc_ctrl
